// ---- hdl/pms_pkg.sv ----
// Shared constants, types and register map of the power-up mode selector and status LED block.
package pms_pkg;

  // System clock and the millisecond time base derived from it.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam logic [15:0] TICKS_PER_MS = 16'(CLK_HZ / MS_PER_S);

  // LED and settle timing in milliseconds; RAPID_BLINKS is a count of blinks.
  localparam logic [11:0] BLINK_ON_MS = 12'h0fa;
  localparam logic [11:0] BLINK_OFF_MS = 12'h0fa;
  localparam logic [11:0] DIGIT_GAP_MS = 12'h2ee;
  localparam logic [11:0] SEPARATOR_MS = 12'h9c4;
  localparam logic [11:0] FAST_FLASH_MS = 12'h064;
  localparam logic [11:0] SETTLE_MS = 12'h00a;
  localparam logic [2:0] RAPID_BLINKS = 3'h3;

  // Switch patterns; a set bit means the switch is closed, bit 0 is switch one.
  localparam logic [3:0] SPECIAL_PAT = 4'hf;
  localparam logic [3:0] PAT_RESTORE = 4'hf;
  localparam logic [3:0] PAT_LOAD_IND = 4'he;
  localparam logic [3:0] PAT_LOAD_STD = 4'hd;

  // Blink code digits.
  localparam logic [2:0] DIG_ERR = 3'h1;
  localparam logic [2:0] DIG_APP_HI = 3'h4;
  localparam logic [2:0] DIG_IND = 3'h1;
  localparam logic [2:0] DIG_STD = 3'h2;
  localparam logic [2:0] DIG_CUS = 3'h3;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0c;
  localparam logic [7:0] ADDR_TICK = 8'h10;

  // Control register fields.
  localparam int CTRL_APP_LSB = 0;
  localparam int CTRL_BOOT = 2;
  localparam int CTRL_ERR = 3;

  // Interrupt status bits.
  localparam int INT_W = 3;
  localparam int INT_CAPTURE = 0;
  localparam int INT_CODE = 1;
  localparam int INT_BADPAT = 2;

  typedef enum logic [1:0] {
    APP_STD = 2'h0,
    APP_IND = 2'h1,
    APP_CUS = 2'h2
  } pms_app_t;

  // Gray code sequence in declaration order, not along the blink path.
  typedef enum logic [2:0] {
    S_RAPID_ON = 3'h0,
    S_RAPID_OFF = 3'h1,
    S_ON = 3'h3,
    S_OFF = 3'h2,
    S_GAP = 3'h6,
    S_SEP = 3'h7,
    S_BOOT_ON = 3'h5,
    S_BOOT_OFF = 3'h4
  } pms_state_t;

  // Outcome of the power-up switch sample.
  typedef struct packed {
    logic special;
    logic restore;
    logic load_ind;
    logic load_std;
  } pms_action_t;

endpackage : pms_pkg

// ---- hdl/pms_sync.sv ----
// Three-stage switch input synchroniser with agreement filter.
`timescale 1ns/1ps
module pms_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] sw_async,
  output logic [7:0] sw_stable
);

  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] s3_ff;

  //////////////////////////////////////////////////////////////////
  // Each bit passes three flops and moves only when stages two and three agree.
  for (genvar i = 0; i < 8; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_ff[i] <= 1'b0;
        s2_ff[i] <= 1'b0;
        s3_ff[i] <= 1'b0;
        sw_stable[i] <= 1'b0;
      end else begin
        s1_ff[i] <= sw_async[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          sw_stable[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule : pms_sync

// ---- hdl/pms_tick.sv ----
// Millisecond tick generator with a software-set period.
`timescale 1ns/1ps
module pms_tick (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] ticks_per_ms,
  output logic ms_tick
);

  logic [15:0] cnt_ff;

  //////////////////////////////////////////////////////////////////
  // Counts clocks and pulses once per period; a zero period acts as one clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
      ms_tick <= 1'b0;
    end else if (cnt_ff + 16'h0001 >= ticks_per_ms) begin
      cnt_ff <= 16'h0000;
      ms_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
      ms_tick <= 1'b0;
    end
  end

endmodule : pms_tick

// ---- hdl/pms_top.sv ----
// Power-up mode selector and health LED blink-code sequencer with APB registers.
`timescale 1ns/1ps
// What this block does
// - Special mode only when switches five to eight are closed; otherwise switches give address.
// - Special mode with switches one to four closed restores factory default settings.
// - Special mode, switch one open, two to four closed loads industrial Ethernet app.
// - Special mode, switch two open, one, three, four closed loads standard app.
// - Code is two digits with pauses; codes are parted by a rapid blink burst.
// - Each counted blink is a quarter second lit, then a quarter second dark unless it is the last blink of its digit.
// - Three quarters of a second dark between first and second digit.
// - Two and a half second separator pause between code repetitions.
// - Codes: 1-1 startup error, 4-1 industrial, 4-2 standard, 4-3 custom app.
// - Bootloader mode flashes 100 ms on, 100 ms off instead of a code.
module pms_top #(
  parameter logic [15:0] TICKS_PER_MS = pms_pkg::TICKS_PER_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] option_sw,
  output logic [7:0] node_addr,
  output pms_pkg::pms_action_t action,
  output logic health_indicator_led,
  output logic irq
);

  // Width of the interrupt status and mask words; it must be declared before the words that use it.
  localparam int INT_W_L = pms_pkg::INT_W;
  logic [7:0] sw_stable;
  logic ms_tick;
  logic [11:0] settle_ff;
  logic captured_ff;
  logic capture_go;
  logic pat_ok;
  logic [1:0] app_ff;
  logic boot_ff;
  logic err_ff;
  logic [15:0] tick_len_ff;
  logic [INT_W_L-1:0] int_stat_ff;
  logic [INT_W_L-1:0] int_mask_ff;
  logic [INT_W_L-1:0] int_set;
  logic wr_en;
  logic rd_hit;
  pms_pkg::pms_state_t st_ff;
  pms_pkg::pms_state_t nxt_st;
  logic [11:0] ms_cnt_ff;
  logic [11:0] dur_ms;
  logic done;
  logic [2:0] blink_ff;
  logic [2:0] nxt_blink;
  logic digit_ff;
  logic nxt_digit;
  logic [2:0] dig_hi;
  logic [2:0] dig_lo;
  logic [2:0] cur_digit;
  logic [31:0] rd_word;

  //////////////////////////////////////////////////////////////////
  // Input conditioning and time base.
  pms_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sw_async(option_sw),
    .sw_stable(sw_stable)
  );

  pms_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ticks_per_ms(tick_len_ff),
    .ms_tick(ms_tick)
  );

  //////////////////////////////////////////////////////////////////
  // Power-up sampling. Switch contacts bounce, so the sample waits a settle time once.
  assign capture_go = !captured_ff && ms_tick && (settle_ff == pms_pkg::SETTLE_MS);
  assign pat_ok = (sw_stable[3:0] == pms_pkg::PAT_RESTORE) ||
                  (sw_stable[3:0] == pms_pkg::PAT_LOAD_IND) ||
                  (sw_stable[3:0] == pms_pkg::PAT_LOAD_STD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_ff <= 12'h000;
      captured_ff <= 1'b0;
    end else if (capture_go) begin
      captured_ff <= 1'b1;
    end else if (!captured_ff && ms_tick) begin
      settle_ff <= settle_ff + 12'h001;
    end
  end

  // Action flags are one-cycle requests; special stays as a level after the sample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      action <= '0;
      node_addr <= 8'h00;
    end else begin
      action.restore <= 1'b0;
      action.load_ind <= 1'b0;
      action.load_std <= 1'b0;
      if (capture_go) begin
        action.special <= (sw_stable[7:4] == pms_pkg::SPECIAL_PAT);
        if (sw_stable[7:4] != pms_pkg::SPECIAL_PAT) begin
          node_addr <= sw_stable;
        end else begin
          action.restore <= (sw_stable[3:0] == pms_pkg::PAT_RESTORE);
          action.load_ind <= (sw_stable[3:0] == pms_pkg::PAT_LOAD_IND);
          action.load_std <= (sw_stable[3:0] == pms_pkg::PAT_LOAD_STD);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // APB slave with no wait states; pready is set for the access phase only.
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_hit = (paddr == pms_pkg::ADDR_CTRL) || (paddr == pms_pkg::ADDR_STATUS) ||
                  (paddr == pms_pkg::ADDR_INT_STAT) || (paddr == pms_pkg::ADDR_INT_MASK) ||
                  (paddr == pms_pkg::ADDR_TICK);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      pms_pkg::ADDR_CTRL: rd_word = {28'h0000000, err_ff, boot_ff, app_ff};
      pms_pkg::ADDR_STATUS: rd_word = {8'h00, 1'b0, st_ff, 1'b0, dig_hi, 1'b0, dig_lo,
                                       captured_ff, action.special, 2'h0, sw_stable};
      pms_pkg::ADDR_INT_STAT: rd_word = {29'h0000000, int_stat_ff};
      pms_pkg::ADDR_INT_MASK: rd_word = {29'h0000000, int_mask_ff};
      pms_pkg::ADDR_TICK: rd_word = {16'h0000, tick_len_ff};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  // Writable control: application code, bootloader flag, error flag and tick length.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      app_ff <= pms_pkg::APP_STD;
      boot_ff <= 1'b0;
      err_ff <= 1'b0;
      tick_len_ff <= TICKS_PER_MS;
      int_mask_ff <= '0;
    end else begin
      if (action.load_ind) begin
        app_ff <= pms_pkg::APP_IND;
      end else if (action.load_std) begin
        app_ff <= pms_pkg::APP_STD;
      end
      if (wr_en && paddr == pms_pkg::ADDR_CTRL) begin
        app_ff <= pwdata[pms_pkg::CTRL_APP_LSB +: 2];
        boot_ff <= pwdata[pms_pkg::CTRL_BOOT];
        err_ff <= pwdata[pms_pkg::CTRL_ERR];
      end
      if (wr_en && paddr == pms_pkg::ADDR_TICK) begin
        tick_len_ff <= pwdata[15:0];
      end
      if (wr_en && paddr == pms_pkg::ADDR_INT_MASK) begin
        int_mask_ff <= pwdata[INT_W_L-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // Sticky interrupt status, cleared by writing one; a new event beats the clear.
  always_comb begin
    int_set = '0;
    int_set[pms_pkg::INT_CAPTURE] = capture_go;
    int_set[pms_pkg::INT_CODE] = (nxt_st == pms_pkg::S_SEP) && (st_ff != pms_pkg::S_SEP);
    int_set[pms_pkg::INT_BADPAT] = capture_go && (sw_stable[7:4] == pms_pkg::SPECIAL_PAT) && !pat_ok;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_ff <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == pms_pkg::ADDR_INT_STAT) begin
        int_stat_ff <= (int_stat_ff & ~pwdata[INT_W_L-1:0]) | int_set;
      end else begin
        int_stat_ff <= int_stat_ff | int_set;
      end
      irq <= |(int_stat_ff & int_mask_ff);
    end
  end

  //////////////////////////////////////////////////////////////////
  // Code digits for the current condition; an error overrides the application code.
  assign dig_hi = err_ff ? pms_pkg::DIG_ERR : pms_pkg::DIG_APP_HI;
  always_comb begin
    case (app_ff)
      pms_pkg::APP_IND: dig_lo = pms_pkg::DIG_IND;
      pms_pkg::APP_CUS: dig_lo = pms_pkg::DIG_CUS;
      default: dig_lo = pms_pkg::DIG_STD;
    endcase
    if (err_ff) begin
      dig_lo = pms_pkg::DIG_ERR;
    end
  end
  assign cur_digit = digit_ff ? dig_lo : dig_hi;

  // Length of the present phase in milliseconds.
  always_comb begin
    case (st_ff)
      pms_pkg::S_ON: dur_ms = pms_pkg::BLINK_ON_MS;
      pms_pkg::S_OFF: dur_ms = pms_pkg::BLINK_OFF_MS;
      pms_pkg::S_GAP: dur_ms = pms_pkg::DIGIT_GAP_MS;
      pms_pkg::S_SEP: dur_ms = pms_pkg::SEPARATOR_MS;
      default: dur_ms = pms_pkg::FAST_FLASH_MS;
    endcase
  end
  assign done = ms_tick && (ms_cnt_ff == 12'(dur_ms - 12'h001));

  //////////////////////////////////////////////////////////////////
  // Sequencer. The last blink of a digit runs straight into the gap or separator,
  // so the dark time there is exactly the pause and not pause plus a blink off.
  always_comb begin
    nxt_st = st_ff;
    nxt_blink = blink_ff;
    nxt_digit = digit_ff;
    if (boot_ff && st_ff != pms_pkg::S_BOOT_ON && st_ff != pms_pkg::S_BOOT_OFF) begin
      nxt_st = pms_pkg::S_BOOT_ON;
    end else if (!boot_ff && (st_ff == pms_pkg::S_BOOT_ON || st_ff == pms_pkg::S_BOOT_OFF)) begin
      nxt_st = pms_pkg::S_ON;
      nxt_blink = 3'h0;
      nxt_digit = 1'b0;
    end else if (done) begin
      case (st_ff)
        pms_pkg::S_ON: begin
          if (blink_ff + 3'h1 >= cur_digit) begin
            nxt_blink = 3'h0;
            nxt_st = digit_ff ? pms_pkg::S_SEP : pms_pkg::S_GAP;
          end else begin
            nxt_blink = blink_ff + 3'h1;
            nxt_st = pms_pkg::S_OFF;
          end
        end
        pms_pkg::S_OFF: nxt_st = pms_pkg::S_ON;
        pms_pkg::S_GAP: begin
          nxt_st = pms_pkg::S_ON;
          nxt_digit = 1'b1;
        end
        pms_pkg::S_SEP: begin
          nxt_st = pms_pkg::S_RAPID_ON;
          nxt_digit = 1'b0;
        end
        pms_pkg::S_RAPID_ON: nxt_st = pms_pkg::S_RAPID_OFF;
        pms_pkg::S_RAPID_OFF: begin
          if (blink_ff + 3'h1 >= pms_pkg::RAPID_BLINKS) begin
            nxt_blink = 3'h0;
            nxt_st = pms_pkg::S_ON;
          end else begin
            nxt_blink = blink_ff + 3'h1;
            nxt_st = pms_pkg::S_RAPID_ON;
          end
        end
        pms_pkg::S_BOOT_ON: nxt_st = pms_pkg::S_BOOT_OFF;
        pms_pkg::S_BOOT_OFF: nxt_st = pms_pkg::S_BOOT_ON;
        default: nxt_st = pms_pkg::S_ON;
      endcase
    end
  end

  // State, phase timer and LED; the LED follows the next state so it lines up with st_ff.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= pms_pkg::S_ON;
      blink_ff <= 3'h0;
      digit_ff <= 1'b0;
      ms_cnt_ff <= 12'h000;
      health_indicator_led <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      blink_ff <= nxt_blink;
      digit_ff <= nxt_digit;
      if (nxt_st != st_ff) begin
        ms_cnt_ff <= 12'h000;
      end else if (ms_tick) begin
        ms_cnt_ff <= ms_cnt_ff + 12'h001;
      end
      health_indicator_led <= (nxt_st == pms_pkg::S_ON) || (nxt_st == pms_pkg::S_RAPID_ON) ||
                              (nxt_st == pms_pkg::S_BOOT_ON);
    end
  end

  //////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_special_gate: assert property (capture_go |=> action.special == (sw_stable[7:4] == 4'hf))
    else $error("special mode flag does not match switches five to eight");
  a_addr_taken: assert property (capture_go && sw_stable[7:4] != 4'hf |=> node_addr == $past(sw_stable))
    else $error("node address not taken from switches");
  a_restore_req: assert property (capture_go && sw_stable == 8'hff |=> action.restore ##1 !action.restore)
    else $error("factory restore request not a single pulse");
  a_load_ind: assert property (capture_go && sw_stable == 8'hfe
                               |=> action.load_ind ##1 app_ff == pms_pkg::APP_IND)
    else $error("industrial application not selected");
  a_load_std: assert property (capture_go && sw_stable == 8'hfd |=> action.load_std && !action.load_ind)
    else $error("standard application not selected");
  a_no_change: assert property (capture_go && sw_stable[7:4] == 4'hf && !pat_ok
                                |=> !action.restore && !action.load_ind && !action.load_std)
    else $error("undefined pattern caused a mode change");
  a_blink_on: assert property (st_ff == pms_pkg::S_ON && done && nxt_st == pms_pkg::S_OFF
                               |=> !health_indicator_led)
    else $error("blink did not go dark after its on time");
  a_gap_dark: assert property (st_ff == pms_pkg::S_GAP
                               |-> !health_indicator_led && ms_cnt_ff < pms_pkg::DIGIT_GAP_MS)
    else $error("digit gap lit or overlong");
  a_sep_next: assert property (st_ff == pms_pkg::S_SEP && done && !boot_ff
                               |=> st_ff == pms_pkg::S_RAPID_ON && health_indicator_led)
    else $error("separator not followed by rapid blink");
  a_code_err: assert property (err_ff |-> dig_hi == 3'h1 && dig_lo == 3'h1)
    else $error("startup error code is not one-one");
  a_boot_flash: assert property (st_ff == pms_pkg::S_BOOT_ON && done && boot_ff
                                 |=> st_ff == pms_pkg::S_BOOT_OFF && !health_indicator_led)
    else $error("bootloader flash did not toggle");
  a_boot_enter: assert property (boot_ff && st_ff != pms_pkg::S_BOOT_ON && st_ff != pms_pkg::S_BOOT_OFF
                                 |=> st_ff == pms_pkg::S_BOOT_ON && health_indicator_led)
    else $error("bootloader request did not start the fast flash");

  // Phase steps of the sequencer and the interrupt path.
  a_off_next: assert property (st_ff == pms_pkg::S_OFF && done && !boot_ff
                               |=> st_ff == pms_pkg::S_ON && health_indicator_led)
    else $error("blink pause not followed by the next blink");
  a_gap_next: assert property (st_ff == pms_pkg::S_GAP && done && !boot_ff
                               |=> st_ff == pms_pkg::S_ON && digit_ff && health_indicator_led)
    else $error("digit gap not followed by the second digit");
  a_burst_end: assert property (st_ff == pms_pkg::S_RAPID_OFF && done && !boot_ff
                                && blink_ff == 3'(pms_pkg::RAPID_BLINKS - 3'h1)
                                |=> st_ff == pms_pkg::S_ON && !digit_ff && blink_ff == 3'h0)
    else $error("rapid burst did not return to the first digit");
  a_capture_flag: assert property (capture_go |=> int_stat_ff[pms_pkg::INT_CAPTURE])
    else $error("sample done flag not set by the power-up sample");
  a_irq_follow: assert property (|(int_stat_ff & int_mask_ff) |=> irq)
    else $error("interrupt not raised for an unmasked status bit");
  a_irq_quiet: assert property (!(|(int_stat_ff & int_mask_ff)) |=> !irq)
    else $error("interrupt raised with no unmasked status bit");

endmodule : pms_top

// ---- verif/pms_panel.sv ----
// Behavioural panel model: option switch bank and a health LED run-length recorder.
`timescale 1ns/1ps
module pms_panel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] sw_val,
  output logic [7:0] option_sw,
  input wire logic led,
  output logic run_done,
  output logic run_lvl,
  output logic [15:0] run_len
);
  logic prev_ff;
  logic lit_ff;
  logic [15:0] cnt_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // A closed switch reads as one; the bank follows sw_val at once, also between power-ups.
  assign option_sw = sw_val;

  // Each finished LED run is reported once, as a one-cycle pulse.
  // Runs before the first light are skipped, since reset time is not a blink.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 1'b0;
      lit_ff <= 1'b0;
      cnt_ff <= 16'h0;
      run_done <= 1'b0;
      run_lvl <= 1'b0;
      run_len <= 16'h0;
    end else begin
      prev_ff <= led;
      run_done <= 1'b0;
      if (led !== prev_ff) begin
        run_done <= lit_ff;
        run_lvl <= prev_ff;
        run_len <= cnt_ff;
        lit_ff <= lit_ff | led;
        cnt_ff <= 16'h1;
      end else begin
        cnt_ff <= cnt_ff + 16'h1;
      end
    end
  end
endmodule : pms_panel

// ---- verif/pms_top_tb.sv ----
// Self-checking bench for the power-up mode selector and health LED sequencer.
`timescale 1ns/1ps
module pms_top_tb;
  localparam int TPM = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, led, run_done, run_lvl, e;
  logic [7:0] paddr, node_addr, option_sw, sw_val, sw;
  logic [31:0] pwdata, prdata, rd, rng, r;
  logic [15:0] run_len;
  logic [3:0] seen_act;
  pms_pkg::pms_action_t action;
  int n_errors, n_checks;
  logic ql[$];
  int qm[$];

  pms_top #(.TICKS_PER_MS(16'(TPM))) u_pms_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .option_sw(option_sw), .node_addr(node_addr),
    .action(action), .health_indicator_led(led), .irq(irq));
  pms_panel u_pms_panel (.pclk(pclk), .presetn(presetn), .sw_val(sw_val), .option_sw(option_sw),
    .led(led), .run_done(run_done), .run_lvl(run_lvl), .run_len(run_len));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Action pulses last one cycle, so they are gathered here until the next reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_act <= 4'h0;
    end else begin
      seen_act <= seen_act | action;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xr();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xr

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic timeout();
    n_errors++;
    results();
  endtask : timeout

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
    n_checks++;
    if (seen !== x) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, x, seen);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) timeout();
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, xr());
    chk(nm, rd, x);
  endtask : rdchk

  // Power up with a switch setting and wait, bounded, until the sample is taken.
  task automatic pwr(input logic [7:0] s);
    int k;
    k = 0;
    @(posedge pclk);
    presetn <= 1'b0;
    sw_val <= s;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    do begin
      apb(1'b0, pms_pkg::ADDR_STATUS, xr());
      k++;
    end while (rd[11] !== 1'b1 && k < 100);
    if (k >= 100) timeout();
    repeat (2) @(posedge pclk);
  endtask : pwr

  // Length is rounded up to whole ticks: a phase begun mid-tick may lose part of one.
  task automatic run_chk(input logic lv, input int ms, input logic skip);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (run_done !== 1'b1 && k < 12000);
    if (k >= 12000) timeout();
    if (!skip) begin
      chk("led_level", {31'h0, run_lvl}, {31'h0, lv});
      chk("led_ms", (32'(run_len) + 32'(TPM - 1)) / 32'(TPM), 32'(ms));
    end
  endtask : run_chk

  // Expected runs: digits, gap, separator, rapid burst, then the first blink of the code again.
  task automatic expect_code(input int hi, input int lo, input int n);
    int c;
    ql.delete();
    qm.delete();
    for (int d = 0; d < 3; d++) begin
      c = (d == 0) ? hi : ((d == 1) ? lo : 1);
      for (int i = 1; i <= c; i++) begin
        ql.push_back(1'b1);
        qm.push_back(250);
        ql.push_back(1'b0);
        qm.push_back(i < c || d == 2 ? 250 : (d == 0 ? 750 : 2500));
      end
      for (int i = 0; i < 3 && d == 1; i++) begin
        ql.push_back(1'b1);
        qm.push_back(100);
        ql.push_back(1'b0);
        qm.push_back(100);
      end
    end
    for (int k = 0; k < n; k++) run_chk(ql[k], qm[k], 1'b0);
  endtask : expect_code

  // Enter bootloader when dark, check the fast flash, then leave with a new control value.
  task automatic restart(input logic [31:0] ctrl);
    int k;
    k = 0;
    while (led !== 1'b0 && k < 12000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 12000) timeout();
    apb(1'b1, pms_pkg::ADDR_CTRL, ctrl | 32'h4);
    run_chk(1'b0, 0, 1'b1);
    run_chk(1'b1, 100, 1'b0);
    run_chk(1'b0, 100, 1'b0);
    run_chk(1'b1, 100, 1'b0);
    apb(1'b1, pms_pkg::ADDR_CTRL, ctrl);
    run_chk(1'b0, 0, 1'b1);
  endtask : restart

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: one power-up per switch case, with the LED codes checked along the way.
  initial begin
    rng = 32'h0000cd2d;
    n_errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sw_val = 8'h00;
    r = xr();
    sw = r[7:0];
    if (sw[7:4] == 4'hf) sw[7] = 1'b0;
    pwr(sw);
    chk("node_addr", {24'h0, node_addr}, {24'h0, sw});
    chk("action", {28'h0, seen_act}, 32'h0);
    rdchk("ctrl", pms_pkg::ADDR_CTRL, 32'h0);
    rdchk("tick", pms_pkg::ADDR_TICK, 32'(TPM));
    rdchk("mask", pms_pkg::ADDR_INT_MASK, 32'h0);
    // Unmapped words above the map: a write is refused and a read returns zero.
    r = xr();
    apb(1'b1, {3'h1, r[4:2], 2'h0}, r);
    chk("unmapped_werr", {31'h0, e}, 32'h1);
    apb(1'b0, {3'h1, r[12:10], 2'h0}, ~r);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    rdchk("int_stat", pms_pkg::ADDR_INT_STAT, 32'h1);
    apb(1'b1, pms_pkg::ADDR_INT_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, pms_pkg::ADDR_INT_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_off", {31'h0, irq}, 32'h0);
    rdchk("int_clr", pms_pkg::ADDR_INT_STAT, 32'h0);
    r = xr();
    apb(1'b1, pms_pkg::ADDR_INT_MASK, r);
    rdchk("mask_rw", pms_pkg::ADDR_INT_MASK, r & 32'h7);
    r = xr();
    apb(1'b1, pms_pkg::ADDR_TICK, r);
    rdchk("tick_rw", pms_pkg::ADDR_TICK, r & 32'hffff);
    sw_val <= ~sw;
    repeat (50) @(posedge pclk);
    chk("node_hold", {24'h0, node_addr}, {24'h0, sw});
    pwr(8'hff);
    chk("action", {28'h0, seen_act}, 32'hc);
    rdchk("tick_reset", pms_pkg::ADDR_TICK, 32'(TPM));
    chk("node_addr", {24'h0, node_addr}, 32'h0);
    pwr(8'hfe);
    chk("action", {28'h0, seen_act}, 32'ha);
    rdchk("ctrl", pms_pkg::ADDR_CTRL, 32'h1);
    expect_code(4, 1, 10);
    rdchk("int_code", pms_pkg::ADDR_INT_STAT, 32'h3);
    r = xr();
    sw = {4'hf, r[3:0]};
    if (sw[3:0] >= 4'hd) sw[3] = 1'b0;
    pwr(sw);
    chk("action", {28'h0, seen_act}, 32'h8);
    chk("node_addr", {24'h0, node_addr}, 32'h0);
    rdchk("int_stat", pms_pkg::ADDR_INT_STAT, 32'h5);
    pwr(8'hfd);
    chk("action", {28'h0, seen_act}, 32'h9);
    rdchk("ctrl", pms_pkg::ADDR_CTRL, 32'h0);
    expect_code(4, 2, 20);
    restart(32'h8);
    expect_code(1, 1, 10);
    restart(32'h2);
    expect_code(4, 3, 9);
    results();
  end
endmodule : pms_top_tb
